// ---- core/pcam_defines.svh ----
// Offsets, field positions, reset values and behaviour notes for the capture/compare array
// Notes on behaviour
// R1: Five modules, six functions, 16-bit except PWM
// R2: Rising pin edge captures 16-bit counter
// R3: Falling pin edge captures 16-bit counter
// R4: Software timer flags counter equals stored value
// R5: High-speed output toggles pin on match
// R6: 8-bit PWM drives duty-controlled pin waveform
// R7: Only module four offers watchdog
// R8: Each module owns one mode control register
// R9: Bit 0 lets event flag raise interrupt
// R10: Bit 1 selects pulse-width modulation mode
// R11: Bit 2 toggles pin on compare match
// R12: Bit 3 sets event flag on match
// R13: Bit 4 falling, bit 5 rising capture
// R14: Bit 6 enables comparator; clear means no matches
// R15: Low/high value bytes hold capture, compare, duty
// R16: Low byte write clears, high sets comparator
// R17: Capture copies counter and sets flag together
`ifndef PCAM_DEFINES_SVH
`define PCAM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define PCAM_NUM_MOD 5
`define PCAM_WDT_MOD 4

// ----------------------------------------------------------------------------
// Register byte offsets (per-module registers step by one word)
// ----------------------------------------------------------------------------
`define PCAM_MODE_BASE 8'h00
`define PCAM_LOW_BASE 8'h20
`define PCAM_HIGH_BASE 8'h40
`define PCAM_STATUS_OFS 8'h60
`define PCAM_MASK_OFS 8'h64
`define PCAM_CTRL_OFS 8'h68
`define PCAM_PINS_OFS 8'h6C

// ----------------------------------------------------------------------------
// Mode control and control register field positions
// ----------------------------------------------------------------------------
`define PCAM_BIT_IRQEN 0
`define PCAM_BIT_PWM 1
`define PCAM_BIT_TOG 2
`define PCAM_BIT_MAT 3
`define PCAM_BIT_FALLING_CAPTURE_ENABLE 4
`define PCAM_BIT_RISING_CAPTURE_ENABLE 5
`define PCAM_BIT_COMPARATOR_ENABLE 6
`define PCAM_CTRL_BIT_WDT 0

// ----------------------------------------------------------------------------
// Reset values, mode read mask and PWM wrap value
// ----------------------------------------------------------------------------
`define PCAM_MODE_RST 8'h00
`define PCAM_VALUE_RST 8'h00
`define PCAM_PIN_RST 1'b1
`define PCAM_MODE_RD_MASK 8'h7F
`define PCAM_PWM_WRAP 8'hFF

`endif

// ---- core/pcam_edge_detect.sv ----
// Pin synchroniser and edge detector for one module pin
`timescale 1ns/10ps
`include "pcam_defines.svh"
module pcam_edge_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pin and events
  input wire logic pin_async,
  output pcam_pkg::pcam_pin_evt_t evt
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // Two flops against metastability, a third to compare for edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= `PCAM_PIN_RST;
      sync2_r <= `PCAM_PIN_RST;
      prev_r <= `PCAM_PIN_RST;
    end else begin
      sync1_r <= pin_async;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign evt.level = sync2_r;
  assign evt.rise = sync2_r & ~prev_r;
  assign evt.fall = ~sync2_r & prev_r;
endmodule // pcam_edge_detect

// ---- core/pcam_irq_status.sv ----
// Sticky event flags, mask and the level interrupt output
`timescale 1ns/10ps
`include "pcam_defines.svh"
module pcam_irq_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Events and per-module enables
  input wire logic [`PCAM_NUM_MOD-1:0] evt_set,
  input wire logic [`PCAM_NUM_MOD-1:0] irq_en,
  // Software access
  input wire logic status_we,
  input wire logic mask_we,
  input wire logic [`PCAM_NUM_MOD-1:0] wdata,
  // State and interrupt
  output logic [`PCAM_NUM_MOD-1:0] status,
  output logic [`PCAM_NUM_MOD-1:0] mask,
  output logic irq
);
  logic [`PCAM_NUM_MOD-1:0] status_r;
  logic [`PCAM_NUM_MOD-1:0] mask_r;

  // Write one to clear; a new event in the same cycle keeps its bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~(status_we ? wdata : '0)) | evt_set;
    end
  end

  // Mask register, same layout as the flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
    end else if (mask_we) begin
      mask_r <= wdata;
    end
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = |(status_r & mask_r & irq_en); // [R9]
endmodule // pcam_irq_status

// ---- core/pcam_pkg.sv ----
// Types shared by the capture/compare array files
package pcam_pkg;

  // Mode control register layout, bit 7 reserved
  typedef struct packed {
    logic reserved;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic output_toggle_enable;
    logic pwm_enable;
    logic event_irq_enable;
  } pcam_mode_t;

  // Per-module pin events from the synchroniser
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pcam_pin_evt_t;

endpackage

// ---- core/pcam_top.sv ----
// Five-module capture/compare/PWM control with its Avalon-MM register slave
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "pcam_defines.svh"
module pcam_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Counter timebase
  input wire logic [15:0] cnt_value,
  input wire logic cnt_tick,
  // Module pins
  input wire logic [`PCAM_NUM_MOD-1:0] module_pin_in,
  output logic [`PCAM_NUM_MOD-1:0] module_pin_out,
  output logic [`PCAM_NUM_MOD-1:0] module_pin_oe,
  // Interrupt and watchdog
  output logic irq,
  output logic wdt_reset
);

  // --------------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------------

  // Hit on the word of module n inside a per-module bank
  function automatic logic bank_hit(input logic [7:0] addr, input logic [7:0] base,
                                    input int unsigned n);
    logic [7:0] ofs;
    ofs = base + 8'(n * 4);
    return addr == ofs;
  endfunction

  // Returns the module index of a bank, or NUM_MOD when not in it
  function automatic logic [2:0] bank_index(input logic [7:0] addr, input logic [7:0] base);
    logic [2:0] idx;
    idx = 3'(`PCAM_NUM_MOD);
    for (int unsigned i = 0; i < `PCAM_NUM_MOD; i++) begin
      if (bank_hit(addr, base, i)) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  logic ack_r;
  logic req;
  logic wr_take;
  logic lane0;

  // One wait state: the answer comes at the second edge of every request
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_take = avs_write & ack_r;
  assign lane0 = avs_byteenable[0];

  // Ack pulses for one cycle; a request held past its completion completes again every second cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  logic [`PCAM_NUM_MOD-1:0] mode_we;
  logic [`PCAM_NUM_MOD-1:0] low_we;
  logic [`PCAM_NUM_MOD-1:0] high_we;
  logic status_we;
  logic mask_we;
  logic ctrl_we;
  logic [7:0] wbyte;

  assign wbyte = avs_writedata[7:0];

  // Register writes land only on the low byte lane
  genvar g;
  generate
    for (g = 0; g < `PCAM_NUM_MOD; g++) begin : g_we
      assign mode_we[g] = wr_take & lane0 & bank_hit(avs_address, `PCAM_MODE_BASE, g);
      assign low_we[g] = wr_take & lane0 & bank_hit(avs_address, `PCAM_LOW_BASE, g);
      assign high_we[g] = wr_take & lane0 & bank_hit(avs_address, `PCAM_HIGH_BASE, g);
    end
  endgenerate

  assign status_we = wr_take & lane0 & (avs_address == `PCAM_STATUS_OFS);
  assign mask_we = wr_take & lane0 & (avs_address == `PCAM_MASK_OFS);
  assign ctrl_we = wr_take & lane0 & (avs_address == `PCAM_CTRL_OFS);

  // --------------------------------------------------------------------------
  // Control register: watchdog enable for module four
  // --------------------------------------------------------------------------
  logic wdt_en_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_en_r <= 1'b0;
    end else if (ctrl_we) begin
      wdt_en_r <= wbyte[`PCAM_CTRL_BIT_WDT];
    end
  end

  // --------------------------------------------------------------------------
  // Per-module state
  // --------------------------------------------------------------------------
  pcam_pkg::pcam_mode_t mode_r [`PCAM_NUM_MOD];
  logic [7:0] low_r [`PCAM_NUM_MOD];
  logic [7:0] high_r [`PCAM_NUM_MOD];
  logic [`PCAM_NUM_MOD-1:0] pin_out_r;
  logic [`PCAM_NUM_MOD-1:0] evt_set;
  logic [`PCAM_NUM_MOD-1:0] irq_en;
  logic [`PCAM_NUM_MOD-1:0] wdt_hit;
  logic [`PCAM_NUM_MOD-1:0] pin_level;
  pcam_pkg::pcam_pin_evt_t pin_evt [`PCAM_NUM_MOD];

  generate
    for (g = 0; g < `PCAM_NUM_MOD; g++) begin : g_mod
      logic capture;
      logic match;
      logic is_pwm;
      logic wdt_mode;
      logic pwm_level;

      // Pin passes two flops before any edge logic sees it
      pcam_edge_detect u_edge (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin_async(module_pin_in[g]),
        .evt(pin_evt[g])
      );

      assign pin_level[g] = pin_evt[g].level;

      // Edge selection: either bit, or both for any transition
      assign capture = (mode_r[g].rising_capture_enable & pin_evt[g].rise) // [R2] [R13]
                     | (mode_r[g].falling_capture_enable & pin_evt[g].fall); // [R3] [R13]

      // Comparator is live only on a counter step, so a stalled counter
      // cannot raise the same match many times
      assign is_pwm = mode_r[g].pwm_enable; // [R10]
      assign match = mode_r[g].comparator_enable & ~is_pwm & cnt_tick // [R14]
                   & (cnt_value == {high_r[g], low_r[g]}); // [R4] [R1]

      // Watchdog exists only on the designated module
      if (g == `PCAM_WDT_MOD) begin : g_wdt
        assign wdt_mode = wdt_en_r & mode_r[g].match_flag_enable; // [R7]
      end else begin : g_nowdt
        assign wdt_mode = 1'b0; // [R7]
      end

      assign wdt_hit[g] = match & wdt_mode;

      // Flag on match or capture; watchdog matches reset instead of flagging
      assign evt_set[g] = (match & mode_r[g].match_flag_enable & ~wdt_mode) // [R12]
                        | capture; // [R17]
      assign irq_en[g] = mode_r[g].event_irq_enable; // [R9]

      // Mode register; value writes steer the comparator enable
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          mode_r[g] <= pcam_pkg::pcam_mode_t'(`PCAM_MODE_RST);
        end else if (mode_we[g]) begin
          mode_r[g] <= pcam_pkg::pcam_mode_t'(wbyte & `PCAM_MODE_RD_MASK); // [R8]
        end else if (high_we[g]) begin
          mode_r[g].comparator_enable <= 1'b1; // [R16]
        end else if (low_we[g]) begin
          mode_r[g].comparator_enable <= 1'b0; // [R16]
        end
      end

      // Low byte: capture beats a software write, PWM reloads from high
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          low_r[g] <= `PCAM_VALUE_RST;
        end else if (capture) begin
          low_r[g] <= cnt_value[7:0]; // [R17] [R15]
        end else if (low_we[g]) begin
          low_r[g] <= wbyte; // [R15]
        end else if (is_pwm & cnt_tick & (cnt_value[7:0] == `PCAM_PWM_WRAP)) begin
          low_r[g] <= high_r[g]; // [R6]
        end
      end

      // High byte: capture beats a software write
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          high_r[g] <= `PCAM_VALUE_RST;
        end else if (capture) begin
          high_r[g] <= cnt_value[15:8]; // [R17] [R15]
        end else if (high_we[g]) begin
          high_r[g] <= wbyte; // [R15]
        end
      end

      // Output high while the counter low byte is at or above the duty byte
      assign pwm_level = cnt_value[7:0] >= low_r[g]; // [R6]

      // Pin output: PWM level, or toggle on each match
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pin_out_r[g] <= `PCAM_PIN_RST;
        end else if (is_pwm) begin
          pin_out_r[g] <= pwm_level; // [R6]
        end else if (match & mode_r[g].output_toggle_enable) begin
          pin_out_r[g] <= ~pin_out_r[g]; // [R5] [R11]
        end
      end

      // Drive the pin only in an output function, else it is a capture input
      assign module_pin_oe[g] = is_pwm | mode_r[g].output_toggle_enable;
    end
  endgenerate

  assign module_pin_out = pin_out_r;

  // --------------------------------------------------------------------------
  // Watchdog reset pulse
  // --------------------------------------------------------------------------
  logic wdt_reset_r;

  // One-cycle pulse per watchdog match
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_reset_r <= 1'b0;
    end else begin
      wdt_reset_r <= |wdt_hit; // [R7]
    end
  end

  assign wdt_reset = wdt_reset_r;

  // --------------------------------------------------------------------------
  // Event flags and interrupt
  // --------------------------------------------------------------------------
  logic [`PCAM_NUM_MOD-1:0] status;
  logic [`PCAM_NUM_MOD-1:0] mask;

  pcam_irq_status u_irq (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .evt_set(evt_set),
    .irq_en(irq_en),
    .status_we(status_we),
    .mask_we(mask_we),
    .wdata(wbyte[`PCAM_NUM_MOD-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [31:0] readdata_r;
  logic [2:0] mode_idx;
  logic [2:0] low_idx;
  logic [2:0] high_idx;

  assign mode_idx = bank_index(avs_address, `PCAM_MODE_BASE);
  assign low_idx = bank_index(avs_address, `PCAM_LOW_BASE);
  assign high_idx = bank_index(avs_address, `PCAM_HIGH_BASE);

  // Unmapped addresses read as zero; reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (mode_idx < 3'(`PCAM_NUM_MOD)) begin
      rd_byte = 8'(mode_r[mode_idx]) & `PCAM_MODE_RD_MASK;
    end else if (low_idx < 3'(`PCAM_NUM_MOD)) begin
      rd_byte = low_r[low_idx];
    end else if (high_idx < 3'(`PCAM_NUM_MOD)) begin
      rd_byte = high_r[high_idx];
    end else if (avs_address == `PCAM_STATUS_OFS) begin
      rd_byte = 8'(status);
    end else if (avs_address == `PCAM_MASK_OFS) begin
      rd_byte = 8'(mask);
    end else if (avs_address == `PCAM_CTRL_OFS) begin
      rd_byte = {7'h00, wdt_en_r};
    end else if (avs_address == `PCAM_PINS_OFS) begin
      rd_byte = {3'h0, pin_level};
    end
  end

  // Data is latched in the wait cycle and stands at the completing edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      readdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign avs_readdata = readdata_r;

endmodule // pcam_top

// ---- verification/pcam_pin_model.sv ----
// Counter timebase and pin driver outside the capture/compare array
`timescale 1ns/10ps
module pcam_pin_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control from the bench
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [4:0] pin_lvl,
  // Towards the block
  output logic [15:0] cnt_value,
  output logic cnt_tick,
  output logic [4:0] module_pin_in
);
  logic [15:0] cnt_r;
  // Counter can be frozen so a capture sees a known count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0000;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (run) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // One tick per counter step; pins idle high like the synchroniser
  assign cnt_value = cnt_r;
  assign cnt_tick = run && !load;
  assign module_pin_in = pin_lvl;
endmodule // pcam_pin_model

// ---- verification/pcam_properties.sv ----
// Port-level assertions for the capture/compare array
`timescale 1ns/10ps
`include "pcam_defines.svh"
module pcam_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Timebase and outputs
  input wire logic cnt_tick,
  input wire logic [`PCAM_NUM_MOD-1:0] module_pin_oe,
  input wire logic irq,
  input wire logic wdt_reset
);
  // ---------------------------------------------------------------
  // Bus transfer steps
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_req_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_wait_single: assert property (s_req_start |-> s_one_wait)
    else $error("waitrequest not exactly one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("readdata upper bits set");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved without a read");
  a_oe_by_write: assert property ($changed(module_pin_oe) |-> $past(avs_write))
    else $error("pin enable moved without a write");
  a_wdt_single: assert property (wdt_reset |=> !wdt_reset)
    else $error("watchdog pulse too long");
  a_wdt_cause: assert property ($rose(wdt_reset) |-> $past(cnt_tick) || $past(cnt_tick, 2))
    else $error("watchdog pulse without a tick");
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
    else $error("interrupt dropped without a write");
endmodule // pcam_properties

// ---- verification/pcam_tb_top.sv ----
// Self-checking bench for the capture/compare array
`timescale 1ns/10ps
`include "pcam_defines.svh"
module pcam_tb_top;
  localparam logic [7:0] MD = `PCAM_MODE_BASE;
  localparam logic [7:0] LO = `PCAM_LOW_BASE;
  localparam logic [7:0] HI = `PCAM_HIGH_BASE;
  localparam logic [7:0] ST = `PCAM_STATUS_OFS;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, cnt_tick, irq, wdt_reset;
  logic run, load;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] cnt_value, load_val;
  logic [4:0] pin_lvl, module_pin_in, module_pin_out, module_pin_oe;
  int num_errors, num_checks, cnt;
  // ---------------------------------------------------------------
  // Design and far side
  // ---------------------------------------------------------------
  pcam_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cnt_value(cnt_value), .cnt_tick(cnt_tick),
    .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
    .module_pin_oe(module_pin_oe), .irq(irq), .wdt_reset(wdt_reset));
  pcam_pin_model u_model (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .load(load),
    .load_val(load_val), .pin_lvl(pin_lvl), .cnt_value(cnt_value), .cnt_tick(cnt_tick),
    .module_pin_in(module_pin_in));
  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is seen low at a falling edge, then drops it after the next rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    logic wt;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    n = 0;
    wt = 1'b1;
    while (wt !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      wt = avs_waitrequest;
      q = avs_readdata;
      @(posedge sys_clk);
      n++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wt !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h00_0000, e}, q);
  endtask
  // Loads the counter, then lets it step if asked
  task automatic go(input logic r, input logic [15:0] v);
    @(posedge sys_clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge sys_clk);
    load <= 1'b0;
    run <= r;
  endtask
  function automatic logic [7:0] ad(input logic [7:0] b, input int n);
    return b + 8'(4 * n);
  endfunction
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {avs_read, avs_write, run, load} = 4'h0;
    avs_address = 8'h00;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h0000_0000;
    load_val = 16'h0000;
    pin_lvl = 5'h1f;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd("mode", ad(MD, i), 8'h00);
      rd("low", ad(LO, i), 8'h00);
      rd("high", ad(HI, i), 8'h00);
    end
    // Reserved bit, unmapped place, disabled byte lane
    wr(ad(MD, 0), 8'hff);
    rd("mode reserved", ad(MD, 0), 8'h7f);
    rd("unmapped", 8'h90, 8'h00);
    avs_byteenable <= 4'h0;
    wr(ad(MD, 0), 8'h00);
    avs_byteenable <= 4'h1;
    rd("lane off", ad(MD, 0), 8'h7f);
    // Value writes move the comparator enable; module 1 toggles
    wr(ad(MD, 0), 8'h09);
    wr(ad(LO, 0), 8'h10);
    wr(ad(HI, 0), 8'h00);
    rd("cmp set", ad(MD, 0), 8'h49);
    wr(ad(LO, 0), 8'h10);
    rd("cmp clear", ad(MD, 0), 8'h09);
    wr(ad(MD, 1), 8'h04);
    wr(ad(LO, 1), 8'h05);
    wr(ad(HI, 1), 8'h00);
    wr(`PCAM_MASK_OFS, 8'h1f);
    rd("mask", `PCAM_MASK_OFS, 8'h1f);
    // Port outputs are looked at mid-cycle, once the last write has landed
    @(negedge sys_clk);
    chk("oe", 32'h0000_0002, module_pin_oe);
    go(1'b1, 16'h0000);
    repeat (40) @(posedge sys_clk);
    run <= 1'b0;
    @(negedge sys_clk);
    chk("pin1 toggled", 32'h0000_0000, module_pin_out[1]);
    rd("no match", ST, 8'h00);
    wr(ad(HI, 0), 8'h00);
    go(1'b1, 16'h0000);
    repeat (40) @(posedge sys_clk);
    run <= 1'b0;
    rd("match flag", ST, 8'h01);
    @(negedge sys_clk);
    chk("irq on", 32'h0000_0001, irq);
    chk("pin1 back", 32'h0000_0001, module_pin_out[1]);
    wr(ad(MD, 0), 8'h48);
    @(negedge sys_clk);
    chk("irq off", 32'h0000_0000, irq);
    wr(ST, 8'h01);
    rd("flag cleared", ST, 8'h00);
    // Captures on a frozen count: module 2 rising, module 3 both edges
    wr(ad(MD, 2), 8'h20);
    wr(ad(MD, 3), 8'h30);
    go(1'b0, 16'h1234);
    pin_lvl <= 5'h13;
    repeat (8) @(posedge sys_clk);
    rd("fall only", ST, 8'h08);
    rd("pin levels", `PCAM_PINS_OFS, 8'h13);
    rd("cap3 low", ad(LO, 3), 8'h34);
    rd("cap3 high", ad(HI, 3), 8'h12);
    rd("no cap2", ad(LO, 2), 8'h00);
    go(1'b0, 16'habcd);
    pin_lvl <= 5'h1f;
    repeat (8) @(posedge sys_clk);
    rd("rise both", ST, 8'h0c);
    rd("cap2 low", ad(LO, 2), 8'hcd);
    rd("cap2 high", ad(HI, 2), 8'hab);
    rd("cap3 rise", ad(LO, 3), 8'hcd);
    wr(ST, 8'h0c);
    // Half duty on module 4 over one full 8-bit period
    wr(ad(LO, 4), 8'h80);
    wr(ad(HI, 4), 8'h80);
    wr(ad(MD, 4), 8'h42);
    @(negedge sys_clk);
    chk("pwm oe", 32'h0000_0012, module_pin_oe);
    go(1'b1, 16'h0000);
    repeat (10) @(posedge sys_clk);
    cnt = 0;
    repeat (256) begin
      @(negedge sys_clk);
      cnt += int'(module_pin_out[4]);
    end
    run <= 1'b0;
    chk("pwm duty", 32'd128, cnt);
    // Watchdog on module 4; module 0 still flags its own match
    wr(ad(MD, 4), 8'h48);
    wr(ad(LO, 4), 8'h20);
    wr(ad(HI, 4), 8'h00);
    wr(`PCAM_CTRL_OFS, 8'h01);
    rd("wdt enable", `PCAM_CTRL_OFS, 8'h01);
    // Old module 0 flag from the PWM run is cleared so the next one is fresh
    wr(ST, 8'h01);
    go(1'b1, 16'h0000);
    cnt = 0;
    repeat (60) begin
      @(negedge sys_clk);
      cnt += int'(wdt_reset);
    end
    run <= 1'b0;
    chk("wdt pulses", 32'd1, cnt);
    rd("wdt no flag", ST, 8'h01);
    wrap_up();
  end
endmodule // pcam_tb_top
bind pcam_top pcam_properties u_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cnt_tick(cnt_tick),
  .module_pin_oe(module_pin_oe), .irq(irq), .wdt_reset(wdt_reset));
